// file: hw/cec_checker.sv
// cec_checker: turns a command's check flags into one error answer
// assumes the command decoder presents flags and a decimal value with a one-cycle strobe
`timescale 1ns/1ps
module cec_checker #(
  parameter int CNT_W = 16
) (
  input wire logic MCLK_IN, // 40 MHz clock
  input wire logic SRST_IN, // sync reset, active high
  input wire logic CMD_VALID_IN, // one-cycle strobe: checks are valid
  input wire cec_pkg::cec_checks_type CHECKS_IN, // check flags
  input wire logic [19:0] NUM_VALUE_IN, // converted ascii number, 20 bits wide
  input wire logic NUM_USED_IN, // command carries an ascii number
  input wire logic PULSE_EN_IN, // enable debug pulse
  output logic RESP_VALID_OUT, // one-cycle: response head valid
  output cec_pkg::cec_resp_type RESP_OUT, // E plus code, or zeros
  output logic CMD_OK_OUT, // one-cycle: command may commit
  output logic [CNT_W-1:0] ERR_COUNT_OUT, // error counter
  output logic ERR_PULSE_OUT // debug pulse pin
);

  // ************************************************************
  // priority encoder
  // ************************************************************
  // the first failing check in this order wins; opcode problems
  // outrank everything because later bytes mean nothing without it
  function automatic logic [7:0] pick_code(input cec_pkg::cec_checks_type c,
                                           input logic ovf);
    logic [7:0] r;
    r = cec_pkg::ERR_NONE;
    if (c.bad_opcode) r = cec_pkg::ERR_BAD_OPCODE;
    else if (c.bad_reset_sequence) r = cec_pkg::ERR_BAD_RESET_SEQUENCE;
    else if (ovf || c.number_overflow) r = cec_pkg::ERR_NUMBER_OVERFLOW;
    else if (c.pin_index_range) r = cec_pkg::ERR_PIN_INDEX_RANGE;
    else if (c.pin_is_host_link) r = cec_pkg::ERR_PIN_IS_HOST_LINK;
    else if (c.bad_pin_mode) r = cec_pkg::ERR_BAD_PIN_MODE;
    else if (c.pin_lacks_hw) r = cec_pkg::ERR_PIN_LACKS_HW;
    else if (c.resource_taken) r = cec_pkg::ERR_RESOURCE_TAKEN;
    else if (c.pin_cmd_unsupported) r = cec_pkg::ERR_PIN_CMD_UNSUPPORTED;
    else if (c.pin_cmd_sequence) r = cec_pkg::ERR_PIN_CMD_SEQUENCE;
    else if (c.write_count_over) r = cec_pkg::ERR_WRITE_COUNT_OVER;
    else if (c.write_addr_out) r = cec_pkg::ERR_WRITE_ADDR_OUT;
    else if (c.write_cont_out) r = cec_pkg::ERR_WRITE_CONT_OUT;
    else if (c.read_addr_out) r = cec_pkg::ERR_READ_ADDR_OUT;
    else if (c.flash_odd_addr) r = cec_pkg::ERR_FLASH_ODD_ADDR;
    else if (c.flash_protected) r = cec_pkg::ERR_FLASH_PROTECTED;
    else if (c.cal_key_wrong) r = cec_pkg::ERR_CAL_KEY_WRONG;
    else if (c.second_link_key) r = cec_pkg::ERR_SECOND_LINK_KEY;
    else if (c.second_link_absent) r = cec_pkg::ERR_SECOND_LINK_ABSENT;
    else if (c.serial_not_ready) r = cec_pkg::ERR_SERIAL_NOT_READY;
    else if (c.bad_baud) r = cec_pkg::ERR_BAD_BAUD;
    else if (c.led_index_range) r = cec_pkg::ERR_LED_INDEX_RANGE;
    else if (c.outscale_subcmd) r = cec_pkg::ERR_OUTSCALE_SUBCMD;
    else if (c.inproc_subcmd) r = cec_pkg::ERR_INPROC_SUBCMD;
    else if (c.poc_entry_range) r = cec_pkg::ERR_POC_ENTRY_RANGE;
    else if (c.poc_submode) r = cec_pkg::ERR_POC_SUBMODE;
    else if (c.pin_param_bad != 5'h00) begin
      // lowest byte position reported first
      for (int i = 4; i >= 0; i--) begin
        if (c.pin_param_bad[i]) r = cec_pkg::ERR_PIN_PARAM_BASE + 8'(i + 3);
      end
    end else if (c.cmd_byte_bad != 7'h00) begin
      for (int i = 6; i >= 0; i--) begin
        if (c.cmd_byte_bad[i]) r = cec_pkg::ERR_CMD_BYTE_BASE + 8'(i + 1);
      end
    end else if (c.no_room) r = cec_pkg::ERR_NO_ROOM;
    return r;
  endfunction

  logic num_ovf;
  logic [7:0] code_now;

  // number overflow check works on the wide converted value
  always_comb begin
    num_ovf = NUM_USED_IN && (NUM_VALUE_IN > {4'h0, cec_pkg::MAX_16});
    code_now = pick_code(CHECKS_IN, num_ovf);
  end
  // remaining code mappings live in pick_code

  // ************************************************************
  // response and counter
  // ************************************************************
  logic resp_valid;
  cec_pkg::cec_resp_type resp;
  logic cmd_ok;
  logic [CNT_W-1:0] err_count;
  logic next_resp_valid;
  cec_pkg::cec_resp_type next_resp;
  logic next_cmd_ok;
  logic [CNT_W-1:0] next_err_count;

  // counter wraps silently; host reads differences, not absolute values
  always_comb begin
    next_resp_valid = CMD_VALID_IN;
    next_resp = resp;
    next_cmd_ok = 1'b0;
    next_err_count = err_count;
    if (CMD_VALID_IN) begin
      if (code_now != cec_pkg::ERR_NONE) begin
        next_resp.lead = cec_pkg::ASCII_E;
        next_resp.code = code_now;
        next_err_count = err_count + 1'b1;
      end else begin
        next_resp = '0;
        next_cmd_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      resp_valid <= 1'b0;
      resp <= '0;
      cmd_ok <= 1'b0;
      err_count <= '0;
    end else begin
      resp_valid <= next_resp_valid;
      resp <= next_resp;
      cmd_ok <= next_cmd_ok;
      err_count <= next_err_count;
    end
  end

  // ************************************************************
  // debug pulse
  // ************************************************************
  cec_pkg::cec_pulse_state_type pstate;
  cec_pkg::cec_pulse_state_type next_pstate;
  logic [7:0] pcnt;
  logic [7:0] next_pcnt;
  logic new_err;

  // an error during a running pulse restarts it, so none is lost
  always_comb begin
    new_err = CMD_VALID_IN && (code_now != cec_pkg::ERR_NONE);
    next_pstate = pstate;
    next_pcnt = pcnt;
    case (pstate)
      cec_pkg::ST_IDLE: begin
        if (new_err && PULSE_EN_IN) begin
          next_pstate = cec_pkg::ST_PULSE;
          next_pcnt = cec_pkg::PULSE_CYCLES - 8'h01;
        end
      end
      cec_pkg::ST_PULSE: begin
        if (new_err && PULSE_EN_IN) next_pcnt = cec_pkg::PULSE_CYCLES - 8'h01;
        else if (pcnt == 8'h00) next_pstate = cec_pkg::ST_IDLE;
        else next_pcnt = pcnt - 8'h01;
      end
      default: next_pstate = cec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      pstate <= cec_pkg::ST_IDLE;
      pcnt <= 8'h00;
    end else begin
      pstate <= next_pstate;
      pcnt <= next_pcnt;
    end
  end

  assign RESP_VALID_OUT = resp_valid;
  assign RESP_OUT = resp;
  assign CMD_OK_OUT = cmd_ok;
  assign ERR_COUNT_OUT = err_count;
  assign ERR_PULSE_OUT = (pstate == cec_pkg::ST_PULSE);

  // ************************************************************
  // assertions
  // ************************************************************
  logic err_in;
  assign err_in = CMD_VALID_IN && (code_now != cec_pkg::ERR_NONE);

  a_err_lead_e: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    err_in |=> RESP_VALID_OUT && RESP_OUT.lead == cec_pkg::ASCII_E)
    else $error("error answer lacks E lead");
  a_count_step: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    err_in |=> ERR_COUNT_OUT == $past(ERR_COUNT_OUT) + 1'b1)
    else $error("error counter did not step");
  a_count_hold: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    !err_in |=> ERR_COUNT_OUT == $past(ERR_COUNT_OUT))
    else $error("error counter moved without error");
  a_pulse_fire: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    err_in && PULSE_EN_IN |=> ERR_PULSE_OUT [*4])
    else $error("debug pulse too short");
  a_num_ovf: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    CMD_VALID_IN && !CHECKS_IN.bad_opcode && !CHECKS_IN.bad_reset_sequence
    && num_ovf |=> RESP_OUT.code == cec_pkg::ERR_NUMBER_OVERFLOW)
    else $error("overflow not coded 2");
  a_opcode_first: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    CMD_VALID_IN && CHECKS_IN.bad_opcode |=> RESP_OUT.code == cec_pkg::ERR_BAD_OPCODE)
    else $error("bad opcode not coded 5");
  a_reset_seq: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    CMD_VALID_IN && !CHECKS_IN.bad_opcode && CHECKS_IN.bad_reset_sequence
    |=> RESP_OUT.code == cec_pkg::ERR_BAD_RESET_SEQUENCE && !CMD_OK_OUT)
    else $error("bad reset sequence not coded 4");
  a_no_commit: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    CMD_OK_OUT |-> RESP_OUT.code == cec_pkg::ERR_NONE && $past(CMD_VALID_IN))
    else $error("commit on failed command");
  a_one_answer: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    RESP_VALID_OUT |-> CMD_OK_OUT != (RESP_OUT.lead == cec_pkg::ASCII_E))
    else $error("answer both ok and error");

  // single-flag commands: each flag asserted below must map to its own code; byte flags at bit 0 only
  logic lone;
  assign lone = CMD_VALID_IN && $onehot(CHECKS_IN) && !num_ovf;

  a_pulse_quiet: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    !PULSE_EN_IN && !ERR_PULSE_OUT |=> !ERR_PULSE_OUT)
    else $error("debug pulse while disabled");
  a_code_pin_mode: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.bad_pin_mode |=> RESP_OUT.code == cec_pkg::ERR_BAD_PIN_MODE)
    else $error("bad pin mode not coded 3");
  a_code_no_room: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.no_room |=> RESP_OUT.code == cec_pkg::ERR_NO_ROOM)
    else $error("no room not coded 6");
  a_code_wr_count: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.write_count_over |=> RESP_OUT.code == cec_pkg::ERR_WRITE_COUNT_OVER)
    else $error("write count not coded 7");
  a_code_wr_addr: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.write_addr_out |=> RESP_OUT.code == cec_pkg::ERR_WRITE_ADDR_OUT)
    else $error("write address not coded 8");
  a_code_wr_cont: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.write_cont_out |=> RESP_OUT.code == cec_pkg::ERR_WRITE_CONT_OUT)
    else $error("write overrun not coded 9");
  a_code_odd_addr: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.flash_odd_addr |=> RESP_OUT.code == cec_pkg::ERR_FLASH_ODD_ADDR)
    else $error("odd flash address not coded 10");
  a_code_flash_prot: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.flash_protected |=> RESP_OUT.code == cec_pkg::ERR_FLASH_PROTECTED)
    else $error("protected flash not coded 11");
  a_code_pin_cmd: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_cmd_unsupported
    |=> RESP_OUT.code == cec_pkg::ERR_PIN_CMD_UNSUPPORTED)
    else $error("pin command not coded 12");
  a_code_pin_order: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_cmd_sequence |=> RESP_OUT.code == cec_pkg::ERR_PIN_CMD_SEQUENCE)
    else $error("pin order not coded 13");
  a_code_led_index: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.led_index_range |=> RESP_OUT.code == cec_pkg::ERR_LED_INDEX_RANGE)
    else $error("led index not coded 14");
  a_code_lacks_hw: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_lacks_hw |=> RESP_OUT.code == cec_pkg::ERR_PIN_LACKS_HW)
    else $error("missing hardware not coded 15");
  a_code_res_taken: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.resource_taken |=> RESP_OUT.code == cec_pkg::ERR_RESOURCE_TAKEN)
    else $error("taken resource not coded 16");
  a_code_param_low: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_param_bad[0]
    |=> RESP_OUT.code == cec_pkg::ERR_PIN_PARAM_BASE + 8'h03)
    else $error("byte 3 parameter not coded 17");
  a_code_pin_high: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_index_range |=> RESP_OUT.code == cec_pkg::ERR_PIN_INDEX_RANGE)
    else $error("pin number not coded 22");
  a_code_host_pin: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.pin_is_host_link |=> RESP_OUT.code == cec_pkg::ERR_PIN_IS_HOST_LINK)
    else $error("host link pin not coded 23");
  a_code_cal_key: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.cal_key_wrong |=> RESP_OUT.code == cec_pkg::ERR_CAL_KEY_WRONG)
    else $error("calibration key not coded 24");
  a_code_link_key: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.second_link_key |=> RESP_OUT.code == cec_pkg::ERR_SECOND_LINK_KEY)
    else $error("second link key not coded 25");
  a_code_link_absent: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.second_link_absent
    |=> RESP_OUT.code == cec_pkg::ERR_SECOND_LINK_ABSENT)
    else $error("absent link not coded 26");
  a_code_serial: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.serial_not_ready |=> RESP_OUT.code == cec_pkg::ERR_SERIAL_NOT_READY)
    else $error("serial not ready not coded 27");
  a_code_cmd_low: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.cmd_byte_bad[0]
    |=> RESP_OUT.code == cec_pkg::ERR_CMD_BYTE_BASE + 8'h01)
    else $error("command byte 1 not coded 28");
  a_code_baud: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.bad_baud |=> RESP_OUT.code == cec_pkg::ERR_BAD_BAUD)
    else $error("baud selector not coded 35");
  a_code_rd_addr: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.read_addr_out |=> RESP_OUT.code == cec_pkg::ERR_READ_ADDR_OUT)
    else $error("read address not coded 43");
  a_code_outscale: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.outscale_subcmd |=> RESP_OUT.code == cec_pkg::ERR_OUTSCALE_SUBCMD)
    else $error("output scaling index not coded 44");
  a_code_inproc: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.inproc_subcmd |=> RESP_OUT.code == cec_pkg::ERR_INPROC_SUBCMD)
    else $error("input processing index not coded 45");
  a_code_poc_entry: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.poc_entry_range |=> RESP_OUT.code == cec_pkg::ERR_POC_ENTRY_RANGE)
    else $error("entry number not coded 46");
  a_code_poc_mode: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
    lone && CHECKS_IN.poc_submode |=> RESP_OUT.code == cec_pkg::ERR_POC_SUBMODE)
    else $error("sub-mode not coded 47");

  c_error: cover property (@(posedge MCLK_IN) err_in);
  c_ok: cover property (@(posedge MCLK_IN) CMD_OK_OUT);
  c_pulse_restart: cover property (@(posedge MCLK_IN) ERR_PULSE_OUT && err_in);

endmodule

// file: inc/cec_pkg.sv
// cec_pkg: shared constants and carrier types for the command error checker
// assumes one 40 MHz clock and a synchronous active-high reset everywhere
package cec_pkg;

  // ************************************************************
  // error codes
  // ************************************************************
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_NUMBER_OVERFLOW = 8'h02;
  localparam logic [7:0] ERR_BAD_PIN_MODE = 8'h03;
  localparam logic [7:0] ERR_BAD_RESET_SEQUENCE = 8'h04;
  localparam logic [7:0] ERR_BAD_OPCODE = 8'h05;
  localparam logic [7:0] ERR_NO_ROOM = 8'h06;
  localparam logic [7:0] ERR_WRITE_COUNT_OVER = 8'h07;
  localparam logic [7:0] ERR_WRITE_ADDR_OUT = 8'h08;
  localparam logic [7:0] ERR_WRITE_CONT_OUT = 8'h09;
  localparam logic [7:0] ERR_FLASH_ODD_ADDR = 8'h0A;
  localparam logic [7:0] ERR_FLASH_PROTECTED = 8'h0B;
  localparam logic [7:0] ERR_PIN_CMD_UNSUPPORTED = 8'h0C;
  localparam logic [7:0] ERR_PIN_CMD_SEQUENCE = 8'h0D;
  localparam logic [7:0] ERR_LED_INDEX_RANGE = 8'h0E;
  localparam logic [7:0] ERR_PIN_LACKS_HW = 8'h0F;
  localparam logic [7:0] ERR_RESOURCE_TAKEN = 8'h10;
  localparam logic [7:0] ERR_PIN_PARAM_BASE = 8'h0E; // byte n gives base + n, 3..7
  localparam logic [7:0] ERR_PIN_INDEX_RANGE = 8'h16;
  localparam logic [7:0] ERR_PIN_IS_HOST_LINK = 8'h17;
  localparam logic [7:0] ERR_CAL_KEY_WRONG = 8'h18;
  localparam logic [7:0] ERR_SECOND_LINK_KEY = 8'h19;
  localparam logic [7:0] ERR_SECOND_LINK_ABSENT = 8'h1A;
  localparam logic [7:0] ERR_SERIAL_NOT_READY = 8'h1B;
  localparam logic [7:0] ERR_CMD_BYTE_BASE = 8'h1B; // byte n gives base + n, 1..7
  localparam logic [7:0] ERR_BAD_BAUD = 8'h23;
  localparam logic [7:0] ERR_READ_ADDR_OUT = 8'h2B;
  localparam logic [7:0] ERR_OUTSCALE_SUBCMD = 8'h2C;
  localparam logic [7:0] ERR_INPROC_SUBCMD = 8'h2D;
  localparam logic [7:0] ERR_POC_ENTRY_RANGE = 8'h2E;
  localparam logic [7:0] ERR_POC_SUBMODE = 8'h2F;

  // ************************************************************
  // packet constants
  // ************************************************************
  localparam logic [7:0] ASCII_E = 8'h45;
  localparam logic [15:0] MAX_16 = 16'hFFFF;
  localparam logic [7:0] PULSE_CYCLES = 8'h04; // width of the debug pulse

  // one flag per check the command decoder has evaluated; decoder owns semantics
  typedef struct packed {
    logic number_overflow;
    logic bad_pin_mode;
    logic bad_reset_sequence;
    logic bad_opcode;
    logic no_room;
    logic write_count_over;
    logic write_addr_out;
    logic write_cont_out;
    logic flash_odd_addr;
    logic flash_protected;
    logic pin_cmd_unsupported;
    logic pin_cmd_sequence;
    logic led_index_range;
    logic pin_lacks_hw;
    logic resource_taken;
    logic [4:0] pin_param_bad; // bit0 = byte 3 .. bit4 = byte 7
    logic pin_index_range;
    logic pin_is_host_link;
    logic cal_key_wrong;
    logic second_link_key;
    logic second_link_absent;
    logic serial_not_ready;
    logic [6:0] cmd_byte_bad; // bit0 = byte 1 .. bit6 = byte 7
    logic bad_baud;
    logic read_addr_out;
    logic outscale_subcmd;
    logic inproc_subcmd;
    logic poc_entry_range;
    logic poc_submode;
  } cec_checks_type;

  // response packet head: first byte and code byte
  typedef struct packed {
    logic [7:0] lead;
    logic [7:0] code;
  } cec_resp_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PULSE = 2'b01
  } cec_pulse_state_type;

endpackage

// file: verification/cec_host_model.sv
// cec_host_model: the host side that presents one checked command per cycle
// assumes the bench calls drive() just after a falling edge of the clock
`timescale 1ns/1ps
module cec_host_model (
  output logic cmd_valid, // one-cycle command strobe
  output cec_pkg::cec_checks_type checks, // check flags of the command
  output logic [19:0] num_value, // converted ascii number
  output logic num_used // command carries a number
);
  // idle values: no strobe, flags cleared
  initial begin
    cmd_valid = 1'b0;
    checks = '0;
    num_value = 20'h00000;
    num_used = 1'b0;
  end
  // one call per cycle; the strobe holds until the next call
  task automatic drive(input logic v, input cec_pkg::cec_checks_type c,
                       input logic [19:0] n, input logic u);
    cmd_valid = v;
    checks = c;
    num_value = n;
    num_used = u;
  endtask
endmodule

// file: verification/command_error_checker_bench.sv
// command_error_checker_bench: self-checking bench for the error answer block
// assumes cec_host_model drives the command side; pulse enable is driven here
`timescale 1ns/1ps
module command_error_checker_bench;
  // ************************************************************
  // clock, reset, wiring
  // ************************************************************
  logic MCLK_IN = 1'b0;
  logic SRST_IN = 1'b1;
  logic PULSE_EN_IN = 1'b0;
  logic CMD_VALID_IN;
  cec_pkg::cec_checks_type CHECKS_IN;
  logic [19:0] NUM_VALUE_IN;
  logic NUM_USED_IN;
  logic RESP_VALID_OUT;
  cec_pkg::cec_resp_type RESP_OUT;
  logic CMD_OK_OUT;
  logic [15:0] ERR_COUNT_OUT;
  logic ERR_PULSE_OUT;
  int error_cnt = 0;
  int checked = 0;
  logic [15:0] exp_cnt = 16'h0000;
  // codes for flag bits 37 down to 0
  logic [7:0] exp_tab [38] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h16,
    8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h22, 8'h21, 8'h20, 8'h1F, 8'h1E, 8'h1D, 8'h1C,
    8'h23, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  always #12.5 MCLK_IN = ~MCLK_IN;
  cec_host_model host (.cmd_valid(CMD_VALID_IN), .checks(CHECKS_IN),
    .num_value(NUM_VALUE_IN), .num_used(NUM_USED_IN));
  cec_checker #(.CNT_W(16)) dut (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
    .CMD_VALID_IN(CMD_VALID_IN), .CHECKS_IN(CHECKS_IN), .NUM_VALUE_IN(NUM_VALUE_IN),
    .NUM_USED_IN(NUM_USED_IN), .PULSE_EN_IN(PULSE_EN_IN), .RESP_VALID_OUT(RESP_VALID_OUT),
    .RESP_OUT(RESP_OUT), .CMD_OK_OUT(CMD_OK_OUT), .ERR_COUNT_OUT(ERR_COUNT_OUT),
    .ERR_PULSE_OUT(ERR_PULSE_OUT));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // drives one command after a falling edge, judges the answer a cycle later
  task automatic issue(input logic [38:0] b, input logic [19:0] v, input logic u,
                       input logic [7:0] code);
    host.drive(1'b1, cec_pkg::cec_checks_type'(b), v, u);
    @(negedge MCLK_IN);
    if (code !== 8'h00) exp_cnt = exp_cnt + 16'h0001;
    chk("resp_valid", 16'h0001, {15'h0000, RESP_VALID_OUT});
    chk("resp", (code === 8'h00) ? 16'h0000 : {cec_pkg::ASCII_E, code}, RESP_OUT);
    chk("cmd_ok", {15'h0000, code === 8'h00}, {15'h0000, CMD_OK_OUT});
    chk("err_count", exp_cnt, ERR_COUNT_OUT);
  endtask
  task automatic idle();
    host.drive(1'b0, '0, 20'h00000, 1'b0);
    @(negedge MCLK_IN);
    chk("resp_valid_drop", 16'h0000, {15'h0000, RESP_VALID_OUT});
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  // every single flag except number_overflow back to back, each must give its own code
  task automatic t_codes();
    for (int i = 37; i >= 0; i--) issue(39'h1 << i, 20'h00000, 1'b0, exp_tab[37-i]);
    idle();
    $display("test codes done");
  endtask
  // number boundary: 65535 passes, 65536 fails only when the number is used
  task automatic t_number();
    issue(39'h0, 20'h0FFFF, 1'b1, 8'h00);
    issue(39'h0, 20'h10000, 1'b1, 8'h02);
    issue(39'h0, 20'h10000, 1'b0, 8'h00);
    issue(39'h1 << 38, 20'h00000, 1'b0, 8'h02);
    idle();
    $display("test number done");
  endtask
  // several failures at once still give one code by fixed priority
  task automatic t_priority();
    issue({39{1'b1}}, 20'hFFFFF, 1'b1, 8'h05);
    issue(39'h1 << 36 | 39'h1 << 38, 20'h10000, 1'b1, 8'h04);
    issue(39'h1 << 34 | 39'h1 << 23, 20'h00000, 1'b0, 8'h15);
    issue(39'h1 << 23 | 39'h1 << 20, 20'h00000, 1'b0, 8'h12);
    issue(39'h1 << 12 | 39'h1 << 8, 20'h00000, 1'b0, 8'h1E);
    idle();
    $display("test priority done");
  endtask
  // debug pulse: four cycles, restarted by a second error, silent when disabled
  task automatic t_pulse();
    int high;
    PULSE_EN_IN = 1'b1;
    high = 0;
    issue(39'h1 << 35, 20'h00000, 1'b0, 8'h05);
    high += ERR_PULSE_OUT;
    for (int k = 0; k < 8; k++) begin
      if (k == 1) issue(39'h1 << 35, 20'h00000, 1'b0, 8'h05);
      else idle();
      high += ERR_PULSE_OUT;
    end
    chk("pulse_cycles", 16'd6, high[15:0]);
    PULSE_EN_IN = 1'b0;
    high = 0;
    issue(39'h1 << 35, 20'h00000, 1'b0, 8'h05);
    for (int k = 0; k < 5; k++) begin
      high += ERR_PULSE_OUT;
      idle();
    end
    chk("pulse_off", 16'd0, high[15:0]);
    $display("test pulse done");
  endtask
  // reset in mid-run clears the counter and answers
  task automatic t_reset();
    SRST_IN = 1'b1;
    repeat (2) @(negedge MCLK_IN);
    SRST_IN = 1'b0;
    exp_cnt = 16'h0000;
    chk("count_reset", 16'h0000, ERR_COUNT_OUT);
    chk("resp_reset", 16'h0000, RESP_OUT);
    issue(39'h1 << 37, 20'h00000, 1'b0, 8'h03);
    idle();
    $display("test reset done");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (5) @(negedge MCLK_IN);
    SRST_IN = 1'b0;
    t_codes();
    t_number();
    t_priority();
    t_pulse();
    t_reset();
    test_done();
  end
  // the whole run is about 75 cycles; this leaves a wide margin
  initial begin
    #(25 * 5000);
    error_cnt++;
    test_done();
  end
endmodule
